// ===== ciop_core.sv
// Execution unit for a subset of integer operations.
// Decode presents one request with req_valid while req_ready is high;
// data memory answers each access with mem_done (and rdata) later.
// Notes on behaviour
// - Nonzero compare-branch jumps only when tested register is not zero.
// - Zero compare-branch jumps only when every bit of register is zero.
// - Mask set disables interrupts; registers and flags stay unchanged.
// - Mask clear re-enables interrupts; registers and flags stay unchanged.
// - Decrement-before load reads listed registers from descending addresses.
// - Increment-after load reads upward words, optional final base writeback.
// - Decrement-before store writes listed registers to descending addresses.
// - Exclusive half load reads and reserves; exclusive store needs reservation.
// - Exclusive half store reports success zero or failure one in Rd.
// - Multiply-accumulate keeps low 32 bits of product plus third register.
// - Multiply-subtract keeps low 32 bits of third minus product.
// - Signed long multiply writes only the low 32 bits of the 64-bit product to Rd.
// - Signed long MAC adds signed product to 64-bit pair value.
// - Word byte swap reverses all four bytes.
// - Halves byte swap exchanges bytes inside each halfword.
// - Low signed swap swaps low halfword bytes and sign-extends.
// - Half sign-extension copies bit 15 of rotated source upward.
// - Half zero-extension clears upper sixteen bits of rotated source.
// - Signed half and byte loads sign-extend memory data to 32 bits.
// - Rotate through carry shifts right one, carry into bit 31, N Z C.
// - Special moves copy between special and general registers.
`timescale 1ns/1ps
`include "ciop_defs.svh"
module ciop_core
   import ciop_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   output logic req_ready,
   input wire ciop_req_t req,
   output ciop_mem_t mem_req,
   input wire logic mem_done,
   input wire logic [`CIOP_XW-1:0] mem_rdata,
   output logic branch_taken,
   output logic [`CIOP_XW-1:0] branch_target,
   output logic irq_masked,
   output ciop_flags_t flags
);
   typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_EXEC, ST_MEM, ST_WB} ciop_state_t;

   ciop_state_t state_q;
   ciop_req_t cur_q;
   logic [`CIOP_XW-1:0] a_v, b_v, c_v;
   logic [`CIOP_XW-1:0] addr_q;
   logic [`CIOP_NREG-1:0] list_q;
   logic excl_valid_q;
   logic [`CIOP_XW-1:0] excl_addr_q;
   logic wr_en;
   logic [`CIOP_RW-1:0] wr_addr;
   logic [`CIOP_XW-1:0] wr_data;
   logic gap_q;
   logic [`CIOP_XW-1:0] hi_data_q;
   logic [`CIOP_RW-1:0] list_idx;
   logic [`CIOP_RW-1:0] list_idx_hi;
   logic [`CIOP_XW-1:0] rot_src;
   logic [`CIOP_XW-1:0] res;
   logic signed [63:0] prod_s;
   logic [63:0] long_res;
   logic [`CIOP_XW:0] add_w;
   logic signed [`CIOP_XW-1:0] sat_max, sat_min;
   ciop_flags_t flags_d;
   logic multi_op, desc_op;

   assign multi_op = cur_q.op inside {CIOP_LOAD_MULTI_DEC_BEFORE,
      CIOP_LOAD_MULTI_INC_AFTER, CIOP_STORE_MULTI_DEC_BEFORE};
   assign desc_op = cur_q.op inside {CIOP_LOAD_MULTI_DEC_BEFORE,
      CIOP_STORE_MULTI_DEC_BEFORE};

   // Lowest and highest listed register still outstanding
   always_comb begin
      list_idx = '0;
      list_idx_hi = '0;
      for (int i = `CIOP_NREG - 1; i >= 0; i--) begin
         if (list_q[i]) list_idx = i[`CIOP_RW-1:0];
      end
      for (int i = 0; i < `CIOP_NREG; i++) begin
         if (list_q[i]) list_idx_hi = i[`CIOP_RW-1:0];
      end
   end

   ciop_regfile u_regfile (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ra_addr(req.rn),
      .rb_addr((state_q != ST_IDLE && desc_op) ? list_idx_hi : req.rm),
      .rc_addr(req.ra),
      .ra_data(a_v),
      .rb_data(b_v),
      .rc_data(c_v),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data)
   );

   assign req_ready = (state_q == ST_IDLE);

   // Operand rotation for the extend forms
   assign rot_src = (b_v >> {cur_q.rot, 3'h0}) | (b_v << (6'd32 - {1'b0, cur_q.rot, 3'h0}));
   assign prod_s = $signed(a_v) * $signed(b_v);
   assign add_w = (cur_q.op == CIOP_SUB) ? {1'b0, a_v} + {1'b0, ~b_v} + 33'h0_0000_0001
      : {1'b0, a_v} + {1'b0, b_v};
   assign sat_max = $signed((32'h0000_0001 << (cur_q.sat_bits - 5'h01)) - 32'h0000_0001);
   assign sat_min = -sat_max - 32'sh0000_0001;

   // Single-cycle result and flags
   always_comb begin
      res = '0;
      long_res = '0;
      flags_d = flags;
      case (cur_q.op)
         CIOP_MUL_ACCUMULATE: res = c_v + a_v * b_v;
         CIOP_MUL_SUBTRACT: res = c_v - a_v * b_v;
         CIOP_SIGNED_MUL_LONG: long_res = prod_s;
         CIOP_SIGNED_MAC_LONG: long_res = prod_s + {hi_data_q, c_v};
         CIOP_BYTE_SWAP_WORD: res = {a_v[7:0], a_v[15:8], a_v[23:16], a_v[31:24]};
         CIOP_BYTE_SWAP_HALVES: res = {a_v[23:16], a_v[31:24], a_v[7:0], a_v[15:8]};
         CIOP_BYTE_SWAP_LOW_SIGNEXT: res = {{16{a_v[7]}}, a_v[7:0], a_v[15:8]};
         CIOP_SIGN_EXT_HALF: res = {{16{rot_src[`CIOP_HALF_SIGN]}}, rot_src[15:0]};
         CIOP_ZERO_EXT_HALF: res = {16'h0000, rot_src[15:0]};
         CIOP_ROTATE_THROUGH_CARRY: begin
            res = {flags.c, b_v[31:1]};
            if (cur_q.set_flags) begin
               flags_d.n = res[`CIOP_SIGN_BIT];
               flags_d.z = (res == '0);
               flags_d.c = b_v[0];
            end
         end
         CIOP_SPECIAL_TO_GENERAL_MOVE: begin
            case (cur_q.spec_sel)
               `CIOP_SPEC_APSR: res = {flags.n, flags.z, flags.c, flags.v, flags.q, 27'h0};
               `CIOP_SPEC_PRIMASK: res = {31'h0, irq_masked};
               default: res = '0;
            endcase
         end
         CIOP_ADD, CIOP_SUB: begin
            res = add_w[`CIOP_XW-1:0];
            if (cur_q.set_flags) begin
               flags_d.n = res[`CIOP_SIGN_BIT];
               flags_d.z = (res == '0);
               flags_d.c = add_w[`CIOP_XW];
               flags_d.v = (cur_q.op == CIOP_ADD)
                  ? (a_v[31] == b_v[31]) && (res[31] != a_v[31])
                  : (a_v[31] != b_v[31]) && (res[31] != a_v[31]);
            end
         end
         CIOP_AND: begin
            res = a_v & b_v;
            if (cur_q.set_flags) begin
               flags_d.n = res[`CIOP_SIGN_BIT];
               flags_d.z = (res == '0);
            end
         end
         CIOP_SSAT: begin
            if ($signed(b_v) > sat_max) begin
               res = sat_max;
               flags_d.q = 1'b1;
            end else if ($signed(b_v) < sat_min) begin
               res = sat_min;
               flags_d.q = 1'b1;
            end else begin
               res = b_v;
            end
         end
         CIOP_GENERAL_TO_SPECIAL_MOVE: begin
            if (cur_q.spec_sel == `CIOP_SPEC_APSR) begin
               flags_d = ciop_flags_t'(a_v[31:27]);
            end
         end
         default: res = '0;
      endcase
   end

   // Sequencer
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         cur_q <= '0;
         addr_q <= '0;
         list_q <= '0;
         gap_q <= 1'b0;
      end else begin
         gap_q <= mem_done; // Idle cycle after a beat lets the next store word be read
         case (state_q)
            ST_IDLE: begin
               if (req_valid) begin
                  cur_q <= req;
                  list_q <= req.reg_list;
                  state_q <= ST_READ;
               end
            end
            ST_READ: begin
               addr_q <= a_v;
               state_q <= multi_op || cur_q.op inside {CIOP_LOAD_EXCL_HALF,
                  CIOP_STORE_EXCL_HALF, CIOP_LOAD_SIGNED_HALF, CIOP_LOAD_SIGNED_BYTE}
                  ? ST_MEM : ST_EXEC;
               if (desc_op) begin
                  addr_q <= a_v - `CIOP_WORD_BYTES;
                  list_q <= cur_q.reg_list;
               end
               if (multi_op && cur_q.reg_list == '0) state_q <= ST_IDLE;
               if (cur_q.op == CIOP_STORE_EXCL_HALF && !(excl_valid_q && excl_addr_q == a_v)) begin
                  state_q <= ST_EXEC;
               end
            end
            ST_MEM: begin
               if (mem_done) begin
                  if (multi_op) begin
                     if (desc_op) begin
                        list_q[list_idx_hi] <= 1'b0;
                        addr_q <= addr_q - `CIOP_WORD_BYTES;
                     end else begin
                        list_q[list_idx] <= 1'b0;
                        addr_q <= addr_q + `CIOP_WORD_BYTES;
                     end
                     if ($countones(list_q) == 1) state_q <= cur_q.writeback ? ST_WB : ST_IDLE;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_EXEC: state_q <= ST_IDLE;
            ST_WB: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // High word of the long accumulator, sampled from port C while reading
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hi_data_q <= '0;
      end else if (state_q == ST_READ) begin
         hi_data_q <= c_v;
      end
   end

   // Memory request for the current transfer
   always_comb begin
      mem_req = '0;
      if (state_q == ST_MEM && !gap_q) begin
         mem_req.valid = 1'b1;
         mem_req.addr = addr_q;
         mem_req.size = 2'h2;
         mem_req.write = (cur_q.op inside {CIOP_STORE_MULTI_DEC_BEFORE, CIOP_STORE_EXCL_HALF});
         mem_req.excl = (cur_q.op inside {CIOP_LOAD_EXCL_HALF, CIOP_STORE_EXCL_HALF});
         mem_req.wdata = (cur_q.op == CIOP_STORE_EXCL_HALF) ? {16'h0000, b_v[15:0]} : b_v;
         if (cur_q.op inside {CIOP_LOAD_EXCL_HALF, CIOP_STORE_EXCL_HALF,
            CIOP_LOAD_SIGNED_HALF}) mem_req.size = 2'h1;
         if (cur_q.op == CIOP_LOAD_SIGNED_BYTE) mem_req.size = 2'h0;
      end
   end

   // Register file write selection
   always_comb begin
      wr_en = 1'b0;
      wr_addr = cur_q.rd;
      wr_data = res;
      if (state_q == ST_MEM && mem_done) begin
         wr_en = !mem_req.write;
         wr_addr = desc_op ? list_idx_hi : (multi_op ? list_idx : cur_q.rd);
         wr_data = mem_rdata;
         if (cur_q.op == CIOP_LOAD_SIGNED_HALF || cur_q.op == CIOP_LOAD_EXCL_HALF) begin
            wr_data = {{16{mem_rdata[`CIOP_HALF_SIGN]}}, mem_rdata[15:0]};
         end
         if (cur_q.op == CIOP_LOAD_EXCL_HALF) wr_data = {16'h0000, mem_rdata[15:0]};
         if (cur_q.op == CIOP_LOAD_SIGNED_BYTE) begin
            wr_data = {{24{mem_rdata[`CIOP_BYTE_SIGN]}}, mem_rdata[7:0]};
         end
         if (cur_q.op == CIOP_STORE_EXCL_HALF) begin
            wr_en = 1'b1;
            wr_data = '0;
         end
      end else if (state_q == ST_EXEC) begin
         wr_en = !(cur_q.op inside {CIOP_NOP, CIOP_COMPARE_BRANCH_NONZERO,
            CIOP_COMPARE_BRANCH_ZERO, CIOP_IRQ_MASK_SET, CIOP_IRQ_MASK_CLEAR,
            CIOP_GENERAL_TO_SPECIAL_MOVE});
         if (cur_q.op == CIOP_STORE_EXCL_HALF) wr_data = 32'h0000_0001;
         if (cur_q.op inside {CIOP_SIGNED_MUL_LONG, CIOP_SIGNED_MAC_LONG}) begin
            wr_data = long_res[31:0];
         end
      end else if (state_q == ST_WB) begin
         wr_en = 1'b1;
         wr_addr = cur_q.rn;
         wr_data = desc_op ? addr_q + `CIOP_WORD_BYTES : addr_q;
      end
   end

   // Exclusive reservation: set by load, consumed by any exclusive store
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         excl_valid_q <= 1'b0;
         excl_addr_q <= '0;
      end else if (state_q == ST_MEM && mem_done && cur_q.op == CIOP_LOAD_EXCL_HALF) begin
         excl_valid_q <= 1'b1;
         excl_addr_q <= addr_q;
      end else if (cur_q.op == CIOP_STORE_EXCL_HALF &&
         (state_q == ST_EXEC || (state_q == ST_MEM && mem_done))) begin
         excl_valid_q <= 1'b0;
      end
   end

   // Flags and interrupt mask
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flags <= `CIOP_FLAGS_RST;
         irq_masked <= `CIOP_PRIMASK_RST;
      end else if (state_q == ST_EXEC) begin
         flags <= flags_d;
         if (cur_q.op == CIOP_IRQ_MASK_SET) irq_masked <= 1'b1;
         if (cur_q.op == CIOP_IRQ_MASK_CLEAR) irq_masked <= 1'b0;
         if (cur_q.op == CIOP_GENERAL_TO_SPECIAL_MOVE && cur_q.spec_sel == `CIOP_SPEC_PRIMASK) begin
            irq_masked <= a_v[0];
         end
      end
   end

   // Compare-and-branch outcome, one-cycle pulse
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         branch_taken <= 1'b0;
         branch_target <= '0;
      end else begin
         branch_taken <= (state_q == ST_EXEC) &&
            ((cur_q.op == CIOP_COMPARE_BRANCH_NONZERO && a_v != '0) ||
             (cur_q.op == CIOP_COMPARE_BRANCH_ZERO && a_v == '0));
         branch_target <= cur_q.target;
      end
   end

   // Checks
   property p_cbz;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_q == ST_EXEC && cur_q.op == CIOP_COMPARE_BRANCH_ZERO) |=> branch_taken == $past(a_v == '0);
   endproperty
   a_cbz: assert property (p_cbz) else $error("zero branch wrong");

   property p_compare_branch_nonzero;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_q == ST_EXEC && cur_q.op == CIOP_COMPARE_BRANCH_NONZERO) |=> branch_taken == $past(a_v != '0);
   endproperty
   a_compare_branch_nonzero: assert property (p_compare_branch_nonzero) else $error("nonzero branch wrong");

   property p_mask_set;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_q == ST_EXEC && cur_q.op == CIOP_IRQ_MASK_SET) |-> !wr_en ##1 irq_masked && $stable(flags);
   endproperty
   a_mask_set: assert property (p_mask_set) else $error("mask set wrong");

   property p_mask_clr;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_q == ST_EXEC && cur_q.op == CIOP_IRQ_MASK_CLEAR) |-> !wr_en ##1 !irq_masked && $stable(flags);
   endproperty
   a_mask_clr: assert property (p_mask_clr) else $error("mask clear wrong");

   sequence s_mem_beat;
      state_q == ST_MEM && mem_done && multi_op && $countones(list_q) > 1;
   endsequence
   property p_multi_dir;
      @(posedge sys_clk) disable iff (!rst_n)
      s_mem_beat |=> addr_q == (desc_op ? $past(addr_q) - 32'h4 : $past(addr_q) + 32'h4);
   endproperty
   a_multi_dir: assert property (p_multi_dir) else $error("multi address step wrong");

   property p_swap;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_q == ST_EXEC && cur_q.op == CIOP_BYTE_SWAP_WORD) |-> wr_en && wr_data[7:0] == a_v[31:24];
   endproperty
   a_swap: assert property (p_swap) else $error("byte swap wrong");

   property p_sbyte;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_q == ST_MEM && mem_done && cur_q.op == CIOP_LOAD_SIGNED_BYTE) |->
         wr_data[31:8] == {24{mem_rdata[7]}};
   endproperty
   a_sbyte: assert property (p_sbyte) else $error("signed byte wrong");

   property p_excl_fail;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_q == ST_EXEC && cur_q.op == CIOP_STORE_EXCL_HALF) |-> wr_data == 32'h1 ##1 !excl_valid_q;
   endproperty
   a_excl_fail: assert property (p_excl_fail) else $error("exclusive fail wrong");
endmodule

// ===== ciop_defs.svh
// Constants for the integer operation subset unit: widths, field positions
// and reset values. Included by the package and the datapath files.
`ifndef CIOP_DEFS_SVH
`define CIOP_DEFS_SVH

`define CIOP_XW 32
`define CIOP_RW 4
`define CIOP_NREG 16
`define CIOP_SIGN_BIT 31
`define CIOP_HALF_SIGN 15
`define CIOP_BYTE_SIGN 7
`define CIOP_WORD_BYTES 32'h0000_0004
`define CIOP_PRIMASK_RST 1'b0
`define CIOP_FLAGS_RST 5'h00
`define CIOP_SPEC_APSR 2'h0
`define CIOP_SPEC_PRIMASK 2'h1
`define CIOP_SPEC_CTRL 2'h2

`endif

// ===== ciop_pkg.sv
// Types for the integer operation subset unit.
// Assumes ciop_defs.svh is on the include path.
`include "ciop_defs.svh"
package ciop_pkg;

   // Operation selected by decode
   typedef enum logic [4:0] {
      CIOP_NOP,
      CIOP_COMPARE_BRANCH_NONZERO,
      CIOP_COMPARE_BRANCH_ZERO,
      CIOP_IRQ_MASK_SET,
      CIOP_IRQ_MASK_CLEAR,
      CIOP_LOAD_MULTI_DEC_BEFORE,
      CIOP_LOAD_MULTI_INC_AFTER,
      CIOP_STORE_MULTI_DEC_BEFORE,
      CIOP_LOAD_EXCL_HALF,
      CIOP_STORE_EXCL_HALF,
      CIOP_MUL_ACCUMULATE,
      CIOP_MUL_SUBTRACT,
      CIOP_SIGNED_MUL_LONG,
      CIOP_SIGNED_MAC_LONG,
      CIOP_BYTE_SWAP_WORD,
      CIOP_BYTE_SWAP_HALVES,
      CIOP_BYTE_SWAP_LOW_SIGNEXT,
      CIOP_SIGN_EXT_HALF,
      CIOP_ZERO_EXT_HALF,
      CIOP_LOAD_SIGNED_HALF,
      CIOP_LOAD_SIGNED_BYTE,
      CIOP_ROTATE_THROUGH_CARRY,
      CIOP_SPECIAL_TO_GENERAL_MOVE,
      CIOP_GENERAL_TO_SPECIAL_MOVE,
      CIOP_ADD,
      CIOP_SUB,
      CIOP_AND,
      CIOP_SSAT
   } ciop_op_t;

   // Condition flags
   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
      logic q;
   } ciop_flags_t;

   // Decoded request from fetch/decode
   typedef struct packed {
      ciop_op_t op;
      logic set_flags;
      logic writeback;
      logic [`CIOP_RW-1:0] rd;
      logic [`CIOP_RW-1:0] rd_hi;
      logic [`CIOP_RW-1:0] rn;
      logic [`CIOP_RW-1:0] rm;
      logic [`CIOP_RW-1:0] ra;
      logic [`CIOP_NREG-1:0] reg_list;
      logic [1:0] rot;
      logic [1:0] spec_sel;
      logic [4:0] sat_bits;
      logic [`CIOP_XW-1:0] target;
   } ciop_req_t;

   // Data memory request
   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] size;
      logic excl;
      logic [`CIOP_XW-1:0] addr;
      logic [`CIOP_XW-1:0] wdata;
   } ciop_mem_t;

endpackage

// ===== ciop_regfile.sv
// General register file of the integer operation subset unit.
// Three combinational-address read ports registered, one write port.
`timescale 1ns/1ps
`include "ciop_defs.svh"
module ciop_regfile
   import ciop_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [`CIOP_RW-1:0] ra_addr,
   input wire logic [`CIOP_RW-1:0] rb_addr,
   input wire logic [`CIOP_RW-1:0] rc_addr,
   output logic [`CIOP_XW-1:0] ra_data,
   output logic [`CIOP_XW-1:0] rb_data,
   output logic [`CIOP_XW-1:0] rc_data,
   input wire logic wr_en,
   input wire logic [`CIOP_RW-1:0] wr_addr,
   input wire logic [`CIOP_XW-1:0] wr_data
);
   logic [`CIOP_XW-1:0] mem_q [`CIOP_NREG];

   // Storage, cleared by reset
   genvar gi;
   generate
      for (gi = 0; gi < `CIOP_NREG; gi++) begin : g_reg
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               mem_q[gi] <= '0;
            end else if (wr_en && wr_addr == gi[`CIOP_RW-1:0]) begin
               mem_q[gi] <= wr_data;
            end
         end
      end
   endgenerate

   // Registered read data
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ra_data <= '0;
         rb_data <= '0;
         rc_data <= '0;
      end else begin
         ra_data <= mem_q[ra_addr];
         rb_data <= mem_q[rb_addr];
         rc_data <= mem_q[rc_addr];
      end
   end
endmodule

// ===== ciop_mem_model.sv
// Data memory model facing the integer operation unit.
// Assumes one access at a time, held steady until mem_done.
`timescale 1ns/1ps
module ciop_mem_model
   import ciop_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire ciop_mem_t mem_req,
   input wire logic [1:0] lat,
   output logic mem_done,
   output logic [31:0] mem_rdata
);
   logic [31:0] mem [0:1023];
   logic [31:0] last_q;
   logic [1:0] cnt_q;
   wire [9:0] idx = mem_req.addr[11:2];

   // Answer after lat wait cycles; idle data line shows inverted junk
   always @(posedge sys_clk) begin
      mem_done <= 1'b0;
      mem_rdata <= ~last_q;
      if (!rst_n) begin
         cnt_q <= 2'h0;
         last_q <= 32'h0;
      end else if (mem_req.valid && !mem_done) begin
         cnt_q <= cnt_q + 2'h1;
         if (cnt_q >= lat) begin
            cnt_q <= 2'h0;
            mem_done <= 1'b1;
            last_q <= mem[idx];
            if (!mem_req.write) mem_rdata <= mem[idx] >> (8 * mem_req.addr[1:0]);
            else if (mem_req.size == 2'h0) mem[idx][8*mem_req.addr[1:0] +: 8] <= mem_req.wdata[7:0];
            else if (mem_req.size == 2'h1) mem[idx][16*mem_req.addr[1] +: 16] <= mem_req.wdata[15:0];
            else mem[idx] <= mem_req.wdata;
         end
      end
   end
endmodule

// ===== testbench.sv
// Self-checking bench for ciop_core with a data memory model.
// Assumes registers are observed only through multi-register stores.
`timescale 1ns/1ps
module testbench
   import ciop_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   logic req_ready, mem_done, branch_taken, irq_masked, br_seen;
   ciop_req_t req = '0;
   ciop_mem_t mem_req;
   logic [31:0] mem_rdata, branch_target, b, v;
   logic [32:0] sum;
   logic [3:0] m;
   ciop_flags_t flags, ef;
   logic [1:0] lat = 2'h0;
   logic [15:0] lfsr_q = 16'hf4d8;
   logic [31:0] exp_r [0:15];
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;
   ciop_op_t ops [9] = '{CIOP_BYTE_SWAP_WORD, CIOP_BYTE_SWAP_HALVES, CIOP_BYTE_SWAP_LOW_SIGNEXT,
      CIOP_SIGN_EXT_HALF, CIOP_ZERO_EXT_HALF, CIOP_MUL_ACCUMULATE, CIOP_MUL_SUBTRACT,
      CIOP_SIGNED_MUL_LONG, CIOP_ROTATE_THROUGH_CARRY};

   ciop_core uut (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .mem_req(mem_req), .mem_done(mem_done), .mem_rdata(mem_rdata),
      .branch_taken(branch_taken), .branch_target(branch_target), .irq_masked(irq_masked),
      .flags(flags));
   ciop_mem_model dmem (.sys_clk(sys_clk), .rst_n(rst_n), .mem_req(mem_req), .lat(lat),
      .mem_done(mem_done), .mem_rdata(mem_rdata));

   // Clock
   always #50 sys_clk = ~sys_clk;

   // Cycle count, hang limit and branch pulse catcher
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (branch_taken === 1'b1) br_seen <= 1'b1;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(string nm, logic e, logic g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %b seen %b", nm, e, g);
      end
   endtask

   // Pseudo-random word from the shift register
   function automatic logic [31:0] rnd();
      logic [31:0] r;
      r = '0;
      for (int k = 0; k < 32; k++) begin
         lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
         r = {r[30:0], lfsr_q[0]};
      end
      return r;
   endfunction

   // Expected result of the register-to-register operations
   function automatic logic [31:0] model(ciop_op_t op, logic [31:0] x, y, z, logic c);
      case (op)
         CIOP_BYTE_SWAP_WORD: return {x[7:0], x[15:8], x[23:16], x[31:24]};
         CIOP_BYTE_SWAP_HALVES: return {x[23:16], x[31:24], x[7:0], x[15:8]};
         CIOP_BYTE_SWAP_LOW_SIGNEXT: return {{16{x[7]}}, x[7:0], x[15:8]};
         CIOP_SIGN_EXT_HALF: return {{16{x[15]}}, x[15:0]};
         CIOP_ZERO_EXT_HALF: return {16'h0000, x[15:0]};
         CIOP_MUL_ACCUMULATE: return x * y + z;
         CIOP_MUL_SUBTRACT: return z - x * y;
         CIOP_ROTATE_THROUGH_CARRY: return {c, x[31:1]};
         default: return x * y;
      endcase
   endfunction

   function automatic ciop_req_t mk(ciop_op_t op, logic [3:0] rd, rn, rm, logic [15:0] lst,
         logic [31:0] tgt, logic [1:0] sel, logic sf);
      return '{op: op, rd: rd, rn: rn, rm: rm, ra: 4'h3, reg_list: lst, target: tgt,
         spec_sel: sel, set_flags: sf, default: '0};
   endfunction

   // One request, then wait for the unit to come back to idle
   task automatic do_op(input ciop_req_t r);
      int n;
      n = 0;
      @(posedge sys_clk);
      req <= r;
      req_valid <= 1'b1;
      br_seen <= 1'b0;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      #1;
      while (req_ready !== 1'b1 && n < 500) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      @(posedge sys_clk);
      #1;
   endtask

   // Store r1..r14 below 0x400 and compare every word
   task automatic dump_check();
      do_op(mk(CIOP_STORE_MULTI_DEC_BEFORE, 4'h0, 4'hf, 4'hf, 16'h7ffe, '0, 2'h0, 1'b0));
      for (int k = 1; k < 15; k++) chk_word("stored reg", exp_r[k], dmem.mem[241 + k]);
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk_bit("ready", 1'b1, req_ready);
      chk_bit("irq", 1'b0, irq_masked);
      chk_word("flags", 32'h0, {27'h0, flags});
      exp_r[0] = 32'h0;
      ef = '0;
      for (int k = 1; k < 16; k++) begin
         exp_r[k] = (k == 15) ? 32'h400 : rnd();
         dmem.mem[k - 1] = exp_r[k];
      end
      do_op(mk(CIOP_LOAD_MULTI_INC_AFTER, 4'h0, 4'h0, 4'h0, 16'hfffe, '0, 2'h0, 1'b0));
      dump_check();
      repeat (6) begin
         v = rnd();
         lat <= v[1:0];
         for (int k = 1; k < 15; k++) begin
            exp_r[k] = rnd();
            dmem.mem[241 + k] = exp_r[k];
         end
         do_op(mk(CIOP_LOAD_MULTI_DEC_BEFORE, 4'h0, 4'hf, 4'hf, 16'h7ffe, '0, 2'h0, 1'b0));
         foreach (ops[i]) begin
            m = (ops[i] inside {CIOP_MUL_ACCUMULATE, CIOP_MUL_SUBTRACT, CIOP_SIGNED_MUL_LONG}) ? 2 : 1;
            b = exp_r[m];
            do_op(mk(ops[i], 4'(4 + i), 4'h1, m, '0, '0, 2'h0, 1'b0));
            exp_r[4 + i] = model(ops[i], exp_r[1], b, exp_r[3], ef.c);
         end
         sum = {1'b0, exp_r[1]} + {1'b0, exp_r[2]};
         ef = '{n: sum[31], z: sum[31:0] == 0, c: sum[32], q: ef.q,
            v: exp_r[1][31] == exp_r[2][31] && sum[31] != exp_r[1][31]};
         exp_r[13] = sum[31:0];
         do_op(mk(CIOP_ADD, 4'hd, 4'h1, 4'h2, '0, '0, 2'h0, 1'b1));
         chk_word("flags", {27'h0, ef}, {27'h0, flags});
         do_op(mk(CIOP_IRQ_MASK_SET, 4'hd, 4'hd, 4'hd, '0, '0, 2'h0, 1'b0));
         chk_bit("irq", 1'b1, irq_masked);
         do_op(mk(CIOP_SPECIAL_TO_GENERAL_MOVE, 4'he, 4'h0, 4'h0, '0, '0, 2'h1, 1'b0));
         exp_r[14] = 32'h1;
         do_op(mk(CIOP_GENERAL_TO_SPECIAL_MOVE, 4'h0, 4'h0, 4'h0, '0, '0, 2'h1, 1'b0));
         chk_bit("irq", 1'b0, irq_masked);
         do_op(mk(CIOP_IRQ_MASK_SET, 4'hd, 4'hd, 4'hd, '0, '0, 2'h0, 1'b0));
         do_op(mk(CIOP_IRQ_MASK_CLEAR, 4'hd, 4'hd, 4'hd, '0, '0, 2'h0, 1'b0));
         chk_bit("irq", 1'b0, irq_masked);
         chk_word("flags", {27'h0, ef}, {27'h0, flags});
         for (int j = 0; j < 4; j++) begin
            v = rnd();
            do_op(mk(j[1] ? CIOP_COMPARE_BRANCH_NONZERO : CIOP_COMPARE_BRANCH_ZERO, 4'h0,
               4'(j % 2), 4'(j % 2), '0, v, 2'h0, 1'b0));
            chk_bit("taken", (exp_r[j % 2] == 0) ^ j[1], br_seen);
            if (br_seen === 1'b1) chk_word("target", v, branch_target);
         end
         dump_check();
      end
      v = rnd() | 32'h8080;
      dmem.mem[0] = v;
      do_op(mk(CIOP_LOAD_SIGNED_HALF, 4'h4, 4'h0, 4'h0, '0, '0, 2'h0, 1'b0));
      do_op(mk(CIOP_LOAD_SIGNED_BYTE, 4'h5, 4'h0, 4'h0, '0, '0, 2'h0, 1'b0));
      do_op(mk(CIOP_LOAD_EXCL_HALF, 4'h6, 4'h0, 4'h0, '0, '0, 2'h0, 1'b0));
      do_op(mk(CIOP_STORE_EXCL_HALF, 4'h7, 4'h0, 4'h1, '0, '0, 2'h0, 1'b0));
      do_op(mk(CIOP_STORE_EXCL_HALF, 4'h8, 4'h0, 4'h1, '0, '0, 2'h0, 1'b0));
      do_op(mk(CIOP_AND, 4'h9, 4'h1, 4'h2, '0, '0, 2'h0, 1'b1));
      exp_r[9] = exp_r[1] & exp_r[2];
      ef.n = exp_r[9][31];
      ef.z = exp_r[9] == 0;
      chk_word("flags", {27'h0, ef}, {27'h0, flags});
      exp_r[4] = {{16{v[15]}}, v[15:0]};
      exp_r[5] = {{24{v[7]}}, v[7:0]};
      exp_r[6] = {16'h0000, v[15:0]};
      exp_r[7] = 32'h0;
      exp_r[8] = 32'h1;
      chk_word("excl store", {v[31:16], exp_r[1][15:0]}, dmem.mem[0]);
      dump_check();
      print_verdict();
   end
endmodule
